/* src/iocs_consts.svh */
// Register offsets, field positions, reset values and timing counts for the I/O status block
`ifndef IOCS_CONSTS_SVH
`define IOCS_CONSTS_SVH

// Register byte offsets
`define IOCS_OFF_IN_STAT 12'h000
`define IOCS_OFF_OUT_STAT 12'h004
`define IOCS_OFF_IN_MODE 12'h008
`define IOCS_OFF_IN_INV 12'h00c
`define IOCS_OFF_DEB_BASE 12'h010
`define IOCS_OFF_DEB_LAST 12'h024
`define IOCS_OFF_OUT_CTRL 12'h028
`define IOCS_OFF_RELAY 12'h02c

// Status word fields
`define IOCS_IN_DI_LSB 0
`define IOCS_IN_THERM_BIT 12
`define IOCS_OUT_DO_LSB 2
`define IOCS_OUT_RELAY_LSB 12

// Output control fields, one byte per output
`define IOCS_OC_STRIDE 8
`define IOCS_OC_MODE_BIT 0
`define IOCS_OC_TYPE_LSB 1
`define IOCS_OC_LEVEL_BIT 3

// Input mode and output mode encodings
`define IOCS_IN_MODE_OFF 2'h0
`define IOCS_IN_MODE_DIG 2'h3
`define IOCS_OUT_MODE_OFF 1'h0
`define IOCS_OUT_MODE_DIG 1'h1

// Reset values
`define IOCS_RST_IN_MODE 12'h000
`define IOCS_RST_IN_INV 6'h00
`define IOCS_RST_DEB 16'h000a
`define IOCS_RST_OUT_CTRL 16'h0000
`define IOCS_RST_RELAY 3'h0

// Debounce time base
`define IOCS_CLK_PERIOD_NS 4
`define IOCS_TICK_NS 1000
`define IOCS_TICK_CYC (`IOCS_TICK_NS / `IOCS_CLK_PERIOD_NS)

`endif

/* src/iocs_pkg.sv */
// Types shared by the I/O status block
`default_nettype none
package iocs_pkg;
  typedef struct packed {
    logic o;
    logic oe;
  } iocs_pin_t;

  typedef enum logic [1:0] {
    IOCS_DRV_TRI = 2'h0,
    IOCS_DRV_SINK = 2'h1,
    IOCS_DRV_SOURCE = 2'h2,
    IOCS_DRV_PUSH = 2'h3
  } iocs_drv_t;

  typedef enum logic {
    IOCS_BUS_IDLE = 1'b0,
    IOCS_BUS_ACK = 1'b1
  } iocs_bus_t;

  typedef struct packed {
    logic mode;
    iocs_drv_t drv;
    logic level;
  } iocs_out_cfg_t;
endpackage : iocs_pkg
`default_nettype wire

/* src/iocs_debounce.sv */
// Debounce filter for one digital input
`timescale 1ns/1ps
`default_nettype none
module iocs_debounce (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic raw,
  input wire logic [15:0] limit,
  output logic stable
);
  logic [15:0] cnt_r;
  logic stable_r;

  // Accept a new level only after it stays put for limit ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 16'h0000;
      stable_r <= 1'b0;
    end else if (raw == stable_r) begin
      cnt_r <= 16'h0000;
    end else if (cnt_r >= limit) begin
      stable_r <= raw;
      cnt_r <= 16'h0000;
    end else if (tick) begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end

  assign stable = stable_r;
endmodule : iocs_debounce
`default_nettype wire

/* src/iocs_top.sv */
// APB-reached digital input, output, relay and thermistor status logic
//
// What this block does
// - Input status bits 0..5 show the six digital inputs in terminal order.
// - Input status bit 12 is high when thermistor resistance exceeds trip level.
// - Output status bits 2,3 show commanded outputs; bits 0-1, 4-11 reserved.
// - Output status bits 12..14 show relays; high means switched to normally-open.
// - Input mode 0 is inactive; mode 3 feeds the input status bit.
// - Input inversion 0 passes the level, 1 inverts it.
// - Each input has its own debounce time; changes must hold that long.
// - All six inputs share the mode encoding, each with own settings.
// - Output mode 0 is inactive, mode 1 enables the digital output.
// - Driver type 0 high impedance, 1 sink, 2 source, 3 push-pull.
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "iocs_consts.svh"
`default_nettype none
module iocs_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic dig_in_a,
  input wire logic dig_in_b,
  input wire logic dig_in_c,
  input wire logic dig_in_d,
  input wire logic dig_in_e,
  input wire logic dig_in_f,
  input wire logic thermistor_sense,
  output iocs_pkg::iocs_pin_t dig_out_a,
  output iocs_pkg::iocs_pin_t dig_out_b,
  output logic relay_a,
  output logic relay_b,
  output logic relay_c
);
  import iocs_pkg::*;

  localparam int TICK_MAX = `IOCS_TICK_CYC - 1;

  iocs_bus_t bus_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic [11:0] in_mode_r;
  logic [5:0] in_inv_r;
  logic [15:0] deb_time_r [6];
  logic [15:0] out_ctrl_r;
  logic [2:0] relay_r;
  logic [15:0] in_status_r;
  logic [15:0] out_status_r;
  iocs_pin_t pin_a_r;
  iocs_pin_t pin_b_r;
  logic [7:0] tick_cnt_r;
  logic tick;
  logic [5:0] raw_in;
  logic [5:0] deb_q;
  logic [5:0] in_bits;
  logic [1:0] out_state;
  logic wr_en;
  logic setup;
  logic mapped;
  logic deb_hit;
  logic [2:0] deb_idx;
  logic [31:0] rd_nxt;
  iocs_out_cfg_t cfg_a;
  iocs_out_cfg_t cfg_b;

  assign raw_in = {dig_in_f, dig_in_e, dig_in_d, dig_in_c, dig_in_b, dig_in_a};
  assign cfg_a = {out_ctrl_r[`IOCS_OC_MODE_BIT], out_ctrl_r[`IOCS_OC_TYPE_LSB +: 2], out_ctrl_r[`IOCS_OC_LEVEL_BIT]};
  assign cfg_b = {out_ctrl_r[`IOCS_OC_STRIDE + `IOCS_OC_MODE_BIT], out_ctrl_r[`IOCS_OC_STRIDE + `IOCS_OC_TYPE_LSB +: 2],
    out_ctrl_r[`IOCS_OC_STRIDE + `IOCS_OC_LEVEL_BIT]};

  // APB handshake: read data captured in setup, answered in access
  assign setup = psel && !penable;
  assign pready = (bus_r == IOCS_BUS_ACK);
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;
  assign wr_en = psel && penable && pready && pwrite && !pslverr_r;

  assign deb_hit = (paddr >= `IOCS_OFF_DEB_BASE) && (paddr <= `IOCS_OFF_DEB_LAST) && (paddr[1:0] == 2'h0);
  assign deb_idx = 3'((paddr - `IOCS_OFF_DEB_BASE) >> 2);

  always_comb begin
    mapped = 1'b1;
    rd_nxt = 32'h0000_0000;
    if (deb_hit) begin
      rd_nxt = {16'h0000, deb_time_r[deb_idx]};
    end else begin
      case (paddr)
        `IOCS_OFF_IN_STAT: rd_nxt = {16'h0000, in_status_r};
        `IOCS_OFF_OUT_STAT: rd_nxt = {16'h0000, out_status_r};
        `IOCS_OFF_IN_MODE: rd_nxt = {20'h00000, in_mode_r};
        `IOCS_OFF_IN_INV: rd_nxt = {26'h0000000, in_inv_r};
        `IOCS_OFF_OUT_CTRL: rd_nxt = {16'h0000, out_ctrl_r};
        `IOCS_OFF_RELAY: rd_nxt = {29'h00000000, relay_r};
        default: mapped = 1'b0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_r <= IOCS_BUS_IDLE;
    end else begin
      case (bus_r)
        IOCS_BUS_IDLE: if (setup) bus_r <= IOCS_BUS_ACK;
        IOCS_BUS_ACK: bus_r <= IOCS_BUS_IDLE;
        default: bus_r <= IOCS_BUS_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      prdata_r <= pwrite ? 32'h0000_0000 : rd_nxt;
      pslverr_r <= !mapped;
    end
  end

  // Configuration registers; status words ignore writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_mode_r <= `IOCS_RST_IN_MODE;
      in_inv_r <= `IOCS_RST_IN_INV;
      out_ctrl_r <= `IOCS_RST_OUT_CTRL;
      relay_r <= `IOCS_RST_RELAY;
    end else if (wr_en) begin
      case (paddr)
        `IOCS_OFF_IN_MODE: in_mode_r <= pwdata[11:0];
        `IOCS_OFF_IN_INV: in_inv_r <= pwdata[5:0];
        `IOCS_OFF_OUT_CTRL: out_ctrl_r <= pwdata[15:0];
        `IOCS_OFF_RELAY: relay_r <= pwdata[2:0];
        default: ;
      endcase
    end
  end

  // Debounce time base
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_r <= 8'h00;
    end else if (tick) begin
      tick_cnt_r <= 8'h00;
    end else begin
      tick_cnt_r <= tick_cnt_r + 8'h01;
    end
  end
  assign tick = (tick_cnt_r == 8'(TICK_MAX));

  // Per-input settings and filter, same encoding for all
  for (genvar i = 0; i < 6; i++) begin : g_in
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        deb_time_r[i] <= `IOCS_RST_DEB;
      end else if (wr_en && deb_hit && deb_idx == 3'(i)) begin
        deb_time_r[i] <= pwdata[15:0];
      end
    end

    iocs_debounce u_deb (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick),
      .raw(raw_in[i]),
      .limit(deb_time_r[i]),
      .stable(deb_q[i])
    );

    // Debounce, then invert, then gate by mode
    assign in_bits[i] = (in_mode_r[2*i +: 2] == `IOCS_IN_MODE_DIG) && (deb_q[i] ^ in_inv_r[i]);
  end

  // Input status word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_status_r <= 16'h0000;
    end else begin
      in_status_r <= 16'h0000;
      in_status_r[`IOCS_IN_DI_LSB +: 6] <= in_bits;
      in_status_r[`IOCS_IN_THERM_BIT] <= thermistor_sense;
    end
  end

  // Commanded output state when enabled
  assign out_state[0] = (cfg_a.mode == `IOCS_OUT_MODE_DIG) && cfg_a.level;
  assign out_state[1] = (cfg_b.mode == `IOCS_OUT_MODE_DIG) && cfg_b.level;

  function automatic iocs_pin_t drive(input iocs_out_cfg_t c);
    iocs_pin_t p;
    p.o = 1'b0;
    p.oe = 1'b0;
    if (c.mode == `IOCS_OUT_MODE_DIG) begin
      case (c.drv)
        IOCS_DRV_TRI: p.oe = 1'b0;
        IOCS_DRV_SINK: p.oe = c.level;
        IOCS_DRV_SOURCE: begin
          p.o = 1'b1;
          p.oe = c.level;
        end
        IOCS_DRV_PUSH: begin
          p.o = c.level;
          p.oe = 1'b1;
        end
        default: p.oe = 1'b0;
      endcase
    end
    return p;
  endfunction : drive

  // Driver type selects how the pin is driven
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_a_r <= '0;
      pin_b_r <= '0;
    end else begin
      pin_a_r <= drive(cfg_a);
      pin_b_r <= drive(cfg_b);
    end
  end
  assign dig_out_a = pin_a_r;
  assign dig_out_b = pin_b_r;
  assign relay_a = relay_r[0];
  assign relay_b = relay_r[1];
  assign relay_c = relay_r[2];

  // Output status word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_status_r <= 16'h0000;
    end else begin
      out_status_r <= 16'h0000;
      out_status_r[`IOCS_OUT_DO_LSB +: 2] <= out_state;
      out_status_r[`IOCS_OUT_RELAY_LSB +: 3] <= relay_r;
    end
  end

  // Checks
  property p_in_map;
    @(posedge pclk) disable iff (!presetn)
    ##1 in_status_r[5:0] == $past(in_bits);
  endproperty
  a_in_map: assert property (p_in_map) else $error("input status does not follow inputs");

  property p_therm;
    @(posedge pclk) disable iff (!presetn)
    $rose(thermistor_sense) |=> in_status_r[12];
  endproperty
  a_therm: assert property (p_therm) else $error("thermistor bit missed");

  property p_out_stat;
    @(posedge pclk) disable iff (!presetn)
    (cfg_a.mode && cfg_a.level) |=> out_status_r[2];
  endproperty
  a_out_stat: assert property (p_out_stat) else $error("output status bit 2 wrong");

  property p_relay;
    @(posedge pclk) disable iff (!presetn)
    wr_en && paddr == `IOCS_OFF_RELAY |=> ##1 out_status_r[14:12] == $past(pwdata[2:0], 2);
  endproperty
  a_relay: assert property (p_relay) else $error("relay status lags command");

  property p_in_off;
    @(posedge pclk) disable iff (!presetn)
    in_mode_r[1:0] != `IOCS_IN_MODE_DIG |=> !in_status_r[0];
  endproperty
  a_in_off: assert property (p_in_off) else $error("inactive input reported");

  property p_inv;
    @(posedge pclk) disable iff (!presetn)
    in_mode_r[1:0] == `IOCS_IN_MODE_DIG |=> in_status_r[0] == ($past(deb_q[0]) ^ $past(in_inv_r[0]));
  endproperty
  a_inv: assert property (p_inv) else $error("inversion not applied");

  property p_deb;
    @(posedge pclk) disable iff (!presetn)
    $changed(deb_q[0]) |-> $past(raw_in[0]) == deb_q[0]
      && ($past(deb_time_r[0]) == 16'h0000 || $past(raw_in[0], 2) == deb_q[0]);
  endproperty
  a_deb: assert property (p_deb) else $error("filter took an unsettled level");

  property p_in_f_off;
    @(posedge pclk) disable iff (!presetn)
    in_mode_r[11:10] == `IOCS_IN_MODE_OFF |=> !in_status_r[5];
  endproperty
  a_in_f_off: assert property (p_in_f_off) else $error("input f mode ignored");

  property p_out_off;
    @(posedge pclk) disable iff (!presetn)
    !cfg_a.mode |=> !dig_out_a.oe && !out_status_r[2];
  endproperty
  a_out_off: assert property (p_out_off) else $error("inactive output drives");

  property p_sink;
    @(posedge pclk) disable iff (!presetn)
    cfg_b.mode && cfg_b.drv == IOCS_DRV_SINK |=> !dig_out_b.o && (dig_out_b.oe == $past(cfg_b.level));
  endproperty
  a_sink: assert property (p_sink) else $error("sink output drives high");

  property p_tri;
    @(posedge pclk) disable iff (!presetn)
    cfg_a.drv == IOCS_DRV_TRI |=> !dig_out_a.oe;
  endproperty
  a_tri: assert property (p_tri) else $error("tri-state output enabled");

  property p_order;
    @(posedge pclk) disable iff (!presetn)
    in_mode_r[3:2] == `IOCS_IN_MODE_DIG && !in_inv_r[1] |=> in_status_r[1] == $past(deb_q[1]);
  endproperty
  a_order: assert property (p_order) else $error("status not from filtered level");

  property p_resv;
    @(posedge pclk) disable iff (!presetn)
    in_status_r[11:6] == 6'h00 && in_status_r[15:13] == 3'h0 && out_status_r[1:0] == 2'h0
      && out_status_r[11:4] == 8'h00 && !out_status_r[15];
  endproperty
  a_resv: assert property (p_resv) else $error("reserved status bit set");

  property p_ro;
    @(posedge pclk) disable iff (!presetn)
    setup && pwrite && paddr == `IOCS_OFF_IN_STAT |=> pready && !pslverr;
  endproperty
  a_ro: assert property (p_ro) else $error("status write not answered cleanly");

  property p_answer;
    @(posedge pclk) disable iff (!presetn)
    setup |=> pready ##1 !pready;
  endproperty
  a_answer: assert property (p_answer) else $error("APB answer timing wrong");

  c_deb: cover property (@(posedge pclk) disable iff (!presetn) $rose(deb_q[2]));
  c_push: cover property (@(posedge pclk) disable iff (!presetn) $rose(dig_out_a.oe) && dig_out_a.o);
  c_err: cover property (@(posedge pclk) disable iff (!presetn) pready && pslverr);
  c_inv: cover property (@(posedge pclk) disable iff (!presetn) in_inv_r[0] && in_status_r[0]);
endmodule : iocs_top
`default_nettype wire

/* tb/iocs_field.sv */
// Field-side model: switches, thermistor wiring and loads on the output terminals
`timescale 1ns/1ps
`default_nettype none
module iocs_field (
  input wire logic pclk,
  input wire logic [5:0] sw,
  input wire logic therm_hi,
  output logic [5:0] din,
  output logic therm,
  input wire iocs_pkg::iocs_pin_t pin_a,
  input wire iocs_pkg::iocs_pin_t pin_b,
  output logic [1:0] load
);
  import iocs_pkg::*;
  // Switch contacts move just after a clock edge
  always_ff @(posedge pclk) begin
    din <= sw;
    therm <= therm_hi;
  end
  // Loads have a pull-down, so a released terminal reads low
  assign load[0] = pin_a.oe ? pin_a.o : 1'b0;
  assign load[1] = pin_b.oe ? pin_b.o : 1'b0;
endmodule : iocs_field
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the I/O status block
`timescale 1ns/1ps
`include "iocs_consts.svh"
`default_nettype none
module tb_top;
  import iocs_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, therm;
  logic therm_hi = 1'b0;
  logic [5:0] sw = 6'h00;
  logic [5:0] din;
  logic [1:0] load;
  logic [2:0] rly;
  iocs_pin_t pin_a, pin_b;
  int failures = 0;
  int cmp_count = 0;
  int cyc = 0;

  always #2 pclk = ~pclk;

  iocs_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dig_in_a(din[0]), .dig_in_b(din[1]), .dig_in_c(din[2]), .dig_in_d(din[3]), .dig_in_e(din[4]),
    .dig_in_f(din[5]), .thermistor_sense(therm), .dig_out_a(pin_a), .dig_out_b(pin_b),
    .relay_a(rly[0]), .relay_b(rly[1]), .relay_c(rly[2]));

  iocs_field fld (.pclk(pclk), .sw(sw), .therm_hi(therm_hi), .din(din), .therm(therm),
    .pin_a(pin_a), .pin_b(pin_b), .load(load));

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
    chk({31'h0, err}, {31'h0, exp_err});
  endtask : rdchk

  task automatic test_reset;
    sw <= 6'h3f;
    repeat (6) @(posedge pclk);
    rdchk(`IOCS_OFF_IN_STAT, 32'h0, 1'b0);
    rdchk(`IOCS_OFF_OUT_STAT, 32'h0, 1'b0);
    rdchk(`IOCS_OFF_DEB_LAST, 32'h0000000a, 1'b0);
    rdchk(12'h030, 32'h0, 1'b1);
    chk({30'h0, pin_a.oe, pin_b.oe}, 32'h0);
    $display("test_reset done");
  endtask : test_reset

  task automatic test_inputs;
    int i;
    for (i = 0; i < 6; i++) apb(1'b1, `IOCS_OFF_DEB_BASE + 12'(4 * i), 32'h0);
    apb(1'b1, `IOCS_OFF_IN_MODE, 32'h00000fff);
    apb(1'b1, `IOCS_OFF_IN_STAT, 32'hffffffff);
    for (i = 0; i < 6; i++) begin
      sw <= 6'(1 << i);
      therm_hi <= i[0];
      repeat (6) @(posedge pclk);
      rdchk(`IOCS_OFF_IN_STAT, {19'h0, i[0], 6'h0, 6'(1 << i)}, 1'b0);
    end
    apb(1'b1, `IOCS_OFF_IN_INV, 32'h00000015);
    sw <= 6'h03;
    therm_hi <= 1'b0;
    repeat (6) @(posedge pclk);
    rdchk(`IOCS_OFF_IN_STAT, 32'h00000016, 1'b0);
    apb(1'b1, `IOCS_OFF_IN_MODE, 32'h00000fd3);
    repeat (4) @(posedge pclk);
    rdchk(`IOCS_OFF_IN_STAT, 32'h00000010, 1'b0);
    $display("test_inputs done");
  endtask : test_inputs

  task automatic test_outputs;
    int t;
    for (t = 0; t < 4; t++) begin
      apb(1'b1, `IOCS_OFF_OUT_CTRL, {20'h0, 1'b1, 2'(t), 1'b1, 4'h0, 1'b1, 2'(t), 1'b1});
      repeat (2) @(posedge pclk);
      chk({30'h0, pin_a.oe, pin_b.oe}, {30'h0, {2{t != 0}}});
      chk({30'h0, load}, {30'h0, {2{t > 1}}});
      rdchk(`IOCS_OFF_OUT_STAT, 32'h0000000c, 1'b0);
    end
    apb(1'b1, `IOCS_OFF_OUT_CTRL, 32'h00000e0e);
    repeat (2) @(posedge pclk);
    chk({30'h0, pin_a.oe, pin_b.oe}, 32'h0);
    rdchk(`IOCS_OFF_OUT_STAT, 32'h0, 1'b0);
    apb(1'b1, `IOCS_OFF_OUT_CTRL, 32'h00000f07);
    apb(1'b1, `IOCS_OFF_RELAY, 32'h00000005);
    repeat (2) @(posedge pclk);
    chk({28'h0, pin_a, pin_b}, 32'h00000007);
    chk({29'h0, rly}, 32'h00000005);
    rdchk(`IOCS_OFF_OUT_STAT, 32'h00005008, 1'b0);
    apb(1'b1, `IOCS_OFF_OUT_STAT, 32'hffffffff);
    apb(1'b1, `IOCS_OFF_RELAY, 32'h00000002);
    repeat (2) @(posedge pclk);
    rdchk(`IOCS_OFF_OUT_STAT, 32'h00002008, 1'b0);
    $display("test_outputs done");
  endtask : test_outputs

  task automatic test_debounce;
    sw <= 6'h00;
    apb(1'b1, `IOCS_OFF_IN_INV, 32'h0);
    apb(1'b1, `IOCS_OFF_DEB_BASE, 32'h00000002);
    sw <= 6'h01;
    repeat (200) @(posedge pclk);
    rdchk(`IOCS_OFF_IN_STAT, 32'h0, 1'b0);
    repeat (600) @(posedge pclk);
    rdchk(`IOCS_OFF_IN_STAT, 32'h00000001, 1'b0);
    sw <= 6'h00;
    repeat (200) @(posedge pclk);
    rdchk(`IOCS_OFF_IN_STAT, 32'h00000001, 1'b0);
    sw <= 6'h01;
    repeat (600) @(posedge pclk);
    rdchk(`IOCS_OFF_IN_STAT, 32'h00000001, 1'b0);
    sw <= 6'h00;
    repeat (600) @(posedge pclk);
    rdchk(`IOCS_OFF_IN_STAT, 32'h0, 1'b0);
    $display("test_debounce done");
  endtask : test_debounce

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      finish_test();
    end
  end

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    test_reset();
    test_inputs();
    test_outputs();
    test_debounce();
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
